// ### hot_insert_two_wire_bus_buffer.sv
// control logic of a hot-insertion two-wire bus buffer
// assumes open-drain pins resolved outside; link_clk runs free
// How it works
// - sense high isolates sides, ready low
// - ready low until connection sequence done
// - ready high only: sense low, sequence done
// - lockout below supply level, lines ignored
// - lockout enables weak card-side precharge
// - after lockout wait backplane stop or idle
// - then require both card lines high
// - all conditions met: join both buses
// - connected: any data low drives both low
// - data high only when all release
// - clock lines joined same wired-AND way
// - sense low again: rerun start-up conditions
// - ready released together with reconnect
`timescale 1ns/1ps
`default_nettype none

module hot_insert_two_wire_bus_buffer
    import hot_insert_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES_P = IDLE_CYCLES
) (
    // core clock, reset, freeze
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // link clock for the bus pins
    input wire logic link_clk,
    // supervision pins
    input wire logic supply_ok,
    input wire logic connection_sense,
    // backplane bus pins
    input wire line_pair_s backplane_line_in,
    output line_pair_s backplane_line_out,
    output line_pair_s backplane_line_oe,
    // card bus pins
    input wire line_pair_s card_line_in,
    output line_pair_s card_line_out,
    output line_pair_s card_line_oe,
    // status pins
    output logic card_precharge_en,
    output logic supply_lockout_state,
    output logic ready_out,
    output logic ready_oe
);

    // ---------------- core clock domain ----------------

    logic [1:0] sup_s;
    logic supply_ok_s;
    logic sense_s;

    pin_sync3 #(
        .W(2),
        .RST(2'h1)
    ) u_sup_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .din({supply_ok, connection_sense}),
        .dout(sup_s)
    );

    assign supply_ok_s = sup_s[1];
    assign sense_s = sup_s[0];

    // synchronised line levels, made in the link domain below
    line_pair_s bp_s;
    line_pair_s card_s;

    // link-domain line levels and stop events into the core domain
    line_pair_s bp_x1_ff;
    line_pair_s bp_x2_ff;
    line_pair_s card_x1_ff;
    line_pair_s card_x2_ff;
    line_pair_s bp_x3_ff;
    line_pair_s card_x3_ff;
    logic stop_x1_ff;
    logic stop_x2_ff;
    logic stop_x3_ff;
    logic stop_tgl_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bp_x1_ff <= LINES_RELEASED;
            bp_x2_ff <= LINES_RELEASED;
            card_x1_ff <= LINES_RELEASED;
            card_x2_ff <= LINES_RELEASED;
            bp_x3_ff <= LINES_RELEASED;
            card_x3_ff <= LINES_RELEASED;
            stop_x1_ff <= 1'b0;
            stop_x2_ff <= 1'b0;
            stop_x3_ff <= 1'b0;
        end else if (ce) begin
            bp_x1_ff <= bp_s;
            bp_x2_ff <= bp_x1_ff;
            card_x1_ff <= card_s;
            card_x2_ff <= card_x1_ff;
            bp_x3_ff <= bp_x2_ff;
            card_x3_ff <= card_x2_ff;
            stop_x1_ff <= stop_tgl_ff;
            stop_x2_ff <= stop_x1_ff;
            stop_x3_ff <= stop_x2_ff;
        end
    end

    logic stop_evt;
    logic idle_hit;
    logic bp_high;
    logic card_high;

    // two bits cross unrelated clocks; a half-crossed word
    // must never read as released, so two samples have to agree
    function automatic logic lines_settled(
        input line_pair_s a,
        input line_pair_s b
    );
        lines_settled = (a == LINES_RELEASED) && (b == LINES_RELEASED);
    endfunction : lines_settled

    assign stop_evt = stop_x2_ff ^ stop_x3_ff;
    assign bp_high = lines_settled(bp_x2_ff, bp_x3_ff);
    assign card_high = lines_settled(card_x2_ff, card_x3_ff);

    conn_state_e state_ff;
    conn_state_e nxt_state;
    logic [IDLE_W-1:0] idle_cnt_ff;

    // idle timer only runs while waiting on the backplane
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_cnt_ff <= IDLE_RST;
        end else if (ce) begin
            if (state_ff != ST_WAIT_BP || !bp_high) begin
                idle_cnt_ff <= IDLE_RST;
            end else if (!idle_hit) begin
                idle_cnt_ff <= idle_cnt_ff + 16'h0001;
            end
        end
    end

    assign idle_hit = (idle_cnt_ff >= IDLE_W'(IDLE_CYCLES_P - 1));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_LOCKOUT: begin
                // lines are not looked at here
                if (supply_ok_s) begin
                    nxt_state = ST_WAIT_BP;
                end
            end
            ST_WAIT_BP: begin
                if (stop_evt || idle_hit) begin
                    nxt_state = ST_WAIT_CARD;
                end
            end
            ST_WAIT_CARD: begin
                if (card_high) begin
                    nxt_state = ST_CONNECTED;
                end
            end
            ST_CONNECTED: begin
                nxt_state = ST_CONNECTED;
            end
            default: begin
                nxt_state = ST_LOCKOUT;
            end
        endcase
        // isolation reruns the whole start-up wait
        if (state_ff != ST_LOCKOUT && sense_s) begin
            nxt_state = ST_WAIT_BP;
        end
        if (!supply_ok_s) begin
            nxt_state = ST_LOCKOUT;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_LOCKOUT;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // connect request and ready move on the same core edge
    logic conn_req_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conn_req_ff <= 1'b0;
            ready_oe <= 1'b1;
            card_precharge_en <= 1'b1;
            supply_lockout_state <= 1'b1;
        end else if (ce) begin
            conn_req_ff <= (nxt_state == ST_CONNECTED);
            ready_oe <= (nxt_state != ST_CONNECTED);
            card_precharge_en <= (nxt_state == ST_LOCKOUT);
            supply_lockout_state <= (nxt_state == ST_LOCKOUT);
        end
    end

    // open drain: only ever pulls low
    assign ready_out = 1'b0;

    // ---------------- link clock domain ----------------

    logic ce_l;

    pin_sync3 #(
        .W(1),
        .RST(1'b0)
    ) u_ce_sync (
        .clk(link_clk),
        .rstn(rstn),
        .ce(1'b1),
        .din(ce),
        .dout(ce_l)
    );

    logic [3:0] lines_s;

    pin_sync3 #(
        .W(4),
        .RST(4'hF)
    ) u_line_sync (
        .clk(link_clk),
        .rstn(rstn),
        .ce(ce_l),
        .din({backplane_line_in, card_line_in}),
        .dout(lines_s)
    );

    assign bp_s = lines_s[3:2];
    assign card_s = lines_s[1:0];

    logic conn_l1_ff;
    logic conn_l2_ff;

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            conn_l1_ff <= 1'b0;
            conn_l2_ff <= 1'b0;
        end else if (ce_l) begin
            conn_l1_ff <= conn_req_ff;
            conn_l2_ff <= conn_l1_ff;
        end
    end

    // stop on the backplane: data rises while clock stays high
    line_pair_s bp_prev_ff;

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            bp_prev_ff <= LINES_RELEASED;
            stop_tgl_ff <= 1'b0;
        end else if (ce_l) begin
            bp_prev_ff <= bp_s;
            if (!bp_prev_ff.data && bp_s.data &&
                bp_prev_ff.clock && bp_s.clock) begin
                stop_tgl_ff <= ~stop_tgl_ff;
            end
        end
    end

    // a low seen on a side that we are not pulling ourselves
    function automatic line_pair_s foreign_low(
        input line_pair_s lvl,
        input line_pair_s own,
        input line_pair_s hold
    );
        foreign_low = ~lvl & ~own & ~hold;
    endfunction : foreign_low

    // after letting go, our own low lingers through the synchroniser;
    // masking the side for a few cycles prevents a latch-up loop
    logic [HOLD_W-1:0] bp_hold_ff [2];
    logic [HOLD_W-1:0] card_hold_ff [2];
    line_pair_s bp_held;
    line_pair_s card_held;
    line_pair_s nxt_bp_oe;
    line_pair_s nxt_card_oe;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            bp_held[i] = (bp_hold_ff[i] != HOLD_RST);
            card_held[i] = (card_hold_ff[i] != HOLD_RST);
        end
        // wired-AND across sides, data and clock alike
        nxt_card_oe = conn_l2_ff ?
            foreign_low(bp_s, backplane_line_oe, bp_held) : 2'h0;
        nxt_bp_oe = conn_l2_ff ?
            foreign_low(card_s, card_line_oe, card_held) : 2'h0;
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            backplane_line_oe <= 2'h0;
            card_line_oe <= 2'h0;
        end else if (ce_l) begin
            backplane_line_oe <= nxt_bp_oe;
            card_line_oe <= nxt_card_oe;
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2; i++) begin
                bp_hold_ff[i] <= HOLD_RST;
                card_hold_ff[i] <= HOLD_RST;
            end
        end else if (ce_l) begin
            for (int i = 0; i < 2; i++) begin
                if (backplane_line_oe[i] && !nxt_bp_oe[i]) begin
                    bp_hold_ff[i] <= HOLD_W'(RELEASE_HOLD);
                end else if (bp_hold_ff[i] != HOLD_RST) begin
                    bp_hold_ff[i] <= bp_hold_ff[i] - 3'h1;
                end
                if (card_line_oe[i] && !nxt_card_oe[i]) begin
                    card_hold_ff[i] <= HOLD_W'(RELEASE_HOLD);
                end else if (card_hold_ff[i] != HOLD_RST) begin
                    card_hold_ff[i] <= card_hold_ff[i] - 3'h1;
                end
            end
        end
    end

    // open drain pins: value low, enable carries the drive
    assign backplane_line_out = 2'h0;
    assign card_line_out = 2'h0;

endmodule : hot_insert_two_wire_bus_buffer

`default_nettype wire

// ### hot_insert_pkg.sv
// shared types and constants for the two-wire hot-insertion buffer
// assumes a 125 MHz core clock and an unrelated link clock
package hot_insert_pkg;

    // one two-wire bus: clock and data line levels or drives
    typedef struct packed {
        logic clock;
        logic data;
    } line_pair_s;

    typedef enum {
        ST_LOCKOUT,
        ST_WAIT_BP,
        ST_WAIT_CARD,
        ST_CONNECTED
    } conn_state_e;

    // core clock
    localparam int CLK_PERIOD_NS = 8;

    // bus idle interval, least time, rounded up to whole cycles
    localparam int IDLE_TIME_US = 95;
    localparam int IDLE_CYCLES =
        (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_W = 16;

    // link cycles a side is ignored after our own drive lets go
    localparam int RELEASE_HOLD = 4;
    localparam int HOLD_W = 3;

    // reset values
    localparam line_pair_s LINES_RELEASED = 2'h3;
    localparam logic [IDLE_W-1:0] IDLE_RST = 16'h0000;
    localparam logic [HOLD_W-1:0] HOLD_RST = 3'h0;

endpackage : hot_insert_pkg

// ### pin_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes inputs asynchronous to clk; output moves once stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // asynchronous level in, filtered level out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end else if (ce) begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a single disagreeing sample never reaches the output
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dout <= RST;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    end

endmodule : pin_sync3

`default_nettype wire

// ### hot_insert_bus_agents.sv
// far-side agents: backplane and card bus parties with pull-ups
// assumes the buffer's oe outputs pull the matching wire low
`timescale 1ns/1ps
`default_nettype none
module hot_insert_bus_agents
    import hot_insert_pkg::*;
(
    // agent drives, 1 = pull low
    input wire line_pair_s bp_pull,
    input wire line_pair_s card_pull,
    input wire logic mated,
    // buffer drives
    input wire line_pair_s bp_oe,
    input wire line_pair_s card_oe,
    // resolved wires
    output line_pair_s bp_lvl,
    output line_pair_s card_lvl,
    output logic sense
);
    // released wire goes high through its pull-up
    assign bp_lvl = ~(bp_pull | bp_oe);
    assign card_lvl = ~(card_pull | card_oe);
    // unmated card leaves sense pulled high
    assign sense = ~mated;
endmodule : hot_insert_bus_agents
`default_nettype wire

// ### hot_insert_two_wire_bus_buffer_checker.sv
// port assertions for the hot-insertion buffer
// assumes bound to the buffer top; core and link clocks
`timescale 1ns/1ps
`default_nettype none
module hot_insert_checker
    import hot_insert_pkg::*;
(
    // clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic rstn,
    // inputs
    input wire logic supply_ok,
    input wire logic connection_sense,
    input wire line_pair_s card_line_in,
    // outputs
    input wire line_pair_s backplane_line_oe,
    input wire line_pair_s card_line_oe,
    input wire logic card_precharge_en,
    input wire logic supply_lockout_state,
    input wire logic ready_oe
);
    property p_pre;
        @(posedge clk) disable iff (!rstn)
        card_precharge_en == supply_lockout_state;
    endproperty
    property p_lock;
        @(posedge clk) disable iff (!rstn) supply_lockout_state |-> ready_oe;
    endproperty
    property p_supply;
        @(posedge clk) disable iff (!rstn)
        !supply_ok [*8] |-> supply_lockout_state;
    endproperty
    property p_sense;
        @(posedge clk) disable iff (!rstn) connection_sense [*8] |-> ready_oe;
    endproperty
    property p_fall;
        @(posedge clk) disable iff (!rstn)
        $fell(ready_oe) |-> !supply_lockout_state;
    endproperty
    // isolation may lag the core by a few link cycles
    property p_iso;
        @(posedge link_clk) disable iff (!rstn)
        ready_oe [*8] |-> (backplane_line_oe | card_line_oe) == 2'h0;
    endproperty
    property p_jdata;
        @(posedge link_clk) disable iff (!rstn)
        (!ready_oe && !card_line_in.data && !card_line_oe.data) [*8]
        |-> ##[0:4] backplane_line_oe.data;
    endproperty
    property p_jclock;
        @(posedge link_clk) disable iff (!rstn)
        (!ready_oe && !card_line_in.clock && !card_line_oe.clock) [*8]
        |-> ##[0:4] backplane_line_oe.clock;
    endproperty
    property p_rel;
        @(posedge link_clk) disable iff (!rstn)
        card_line_in.data [*8] |-> !backplane_line_oe.data;
    endproperty
    a_pre: assert property (p_pre) else $error("precharge mismatch");
    a_lock: assert property (p_lock) else $error("ready in lockout");
    a_supply: assert property (p_supply) else $error("no lockout");
    a_sense: assert property (p_sense) else $error("ready while sensed");
    a_fall: assert property (p_fall) else $error("bad ready release");
    a_iso: assert property (p_iso) else $error("drive while isolated");
    a_jdata: assert property (p_jdata) else $error("data not joined");
    a_jclock: assert property (p_jclock) else $error("clock not joined");
    a_rel: assert property (p_rel) else $error("data held low");
    c_conn: cover property (@(posedge clk) $fell(ready_oe));
    c_up: cover property (@(posedge clk) $fell(supply_lockout_state));
    c_join: cover property (@(posedge link_clk) $rose(card_line_oe.clock));
endmodule : hot_insert_checker
bind hot_insert_two_wire_bus_buffer hot_insert_checker chk (
    .clk(clk),
    .link_clk(link_clk),
    .rstn(rstn),
    .supply_ok(supply_ok),
    .connection_sense(connection_sense),
    .card_line_in(card_line_in),
    .backplane_line_oe(backplane_line_oe),
    .card_line_oe(card_line_oe),
    .card_precharge_en(card_precharge_en),
    .supply_lockout_state(supply_lockout_state),
    .ready_oe(ready_oe)
);
`default_nettype wire

// ### hot_insert_two_wire_bus_buffer_test.sv
// self-checking bench for the hot-insertion buffer
// assumes agents model resolves wires; idle timer shortened
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module hot_insert_two_wire_bus_buffer_test
    import hot_insert_pkg::*;
;
    // {bp pull, card pull, bp level, card level}
    localparam logic [7:0] ROWS [7] = '{8'h4A, 8'h1A, 8'h85, 8'h25, 8'h5A,
        8'h90, 8'h0F};
    logic clk, link_clk, rstn, supply_ok, mated, sense;
    logic precharge, lockout, ready_oe;
    line_pair_s bp_pull, card_pull, bp_lvl, card_lvl, bp_oe, card_oe;
    int miscompares, cmp_count;
    logic ready_od;
    line_pair_s bp_od, card_od;
    hot_insert_bus_agents agents (.bp_pull(bp_pull), .card_pull(card_pull),
        .mated(mated), .bp_oe(bp_oe), .card_oe(card_oe), .bp_lvl(bp_lvl),
        .card_lvl(card_lvl), .sense(sense));
    hot_insert_two_wire_bus_buffer #(.IDLE_CYCLES_P(50)) uut (.clk(clk),
        .rstn(rstn), .ce(1'b1), .link_clk(link_clk), .supply_ok(supply_ok),
        .connection_sense(sense), .backplane_line_in(bp_lvl),
        .backplane_line_out(bp_od), .backplane_line_oe(bp_oe),
        .card_line_in(card_lvl), .card_line_out(card_od),
        .card_line_oe(card_oe),
        .card_precharge_en(precharge), .supply_lockout_state(lockout),
        .ready_out(ready_od), .ready_oe(ready_oe));
    always #4 clk = ~clk;
    // odd offset keeps link edges off core edges
    initial begin
        #5;
        forever #24 link_clk = ~link_clk;
    end
    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask : clks
    task automatic wait_ready(input logic v);
        int i;
        for (i = 0; i < 2000 && ready_oe !== v; i++) @(negedge clk);
    endtask : wait_ready
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // run needs about 21 us
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
    initial begin
        clk = 1'b0;
        link_clk = 1'b0;
        rstn = 1'b0;
        supply_ok = 1'b0;
        mated = 1'b1;
        bp_pull = 2'h1;
        card_pull = 2'h1;
        clks(16);
        `CHK(ready_oe, 1'b1)
        `CHK(precharge, 1'b1)
        rstn = 1'b1;
        bp_pull = 2'h3;
        clks(40);
        bp_pull = 2'h1;
        clks(40);
        `CHK(lockout, 1'b1)
        `CHK(card_lvl, 2'h2)
        supply_ok = 1'b1;
        clks(300);
        `CHK(precharge, 1'b0)
        `CHK(ready_oe, 1'b1)
        bp_pull = 2'h0;
        clks(300);
        `CHK(ready_oe, 1'b1)
        card_pull = 2'h0;
        wait_ready(1'b0);
        `CHK(ready_oe, 1'b0)
        foreach (ROWS[r]) begin
            bp_pull = ROWS[r][7:6];
            card_pull = ROWS[r][5:4];
            clks(100);
            `CHK(bp_lvl, ROWS[r][3:2])
            `CHK(card_lvl, ROWS[r][1:0])
            bp_pull = 2'h0;
            card_pull = 2'h0;
            clks(100);
        end
        mated = 1'b0;
        wait_ready(1'b1);
        `CHK(ready_oe, 1'b1)
        bp_pull = 2'h1;
        clks(100);
        `CHK(card_lvl, 2'h3)
        // clock low first so the data release is no stop
        bp_pull = 2'h3;
        clks(20);
        bp_pull = 2'h2;
        mated = 1'b1;
        clks(300);
        `CHK(ready_oe, 1'b1)
        bp_pull = 2'h0;
        wait_ready(1'b0);
        `CHK(ready_oe, 1'b0)
        supply_ok = 1'b0;
        clks(20);
        `CHK(lockout, 1'b1)
        `CHK(ready_oe, 1'b1)
        `CHK({ready_od, bp_od, card_od}, 5'h00)
        complete_run();
    end
endmodule : hot_insert_two_wire_bus_buffer_test
`default_nettype wire
